/* hw/mxu_apb.v */
// APB slave front end: decodes byte offsets to register select lines
// assumes the unit adds one wait state and answers on the second access edge
`include "mxu_defs.vh"
module mxu_apb (
  input wire [11:0] paddr,
  input wire psel,
  input wire penable,
  input wire pwrite,
  output reg [7:0] sel,
  output reg wrStb,
  output reg rdStb,
  output reg hit
);
  // ===========================================================
  // address decode
  always @* begin
    sel = 8'h00;
    case (paddr)
      `MXU_REG_CMD: sel = 8'h01;
      `MXU_REG_STATUS: sel = 8'h02;
      `MXU_REG_FILTER: sel = 8'h04;
      `MXU_REG_ADDRHI: sel = 8'h08;
      `MXU_REG_ADDRLO: sel = 8'h10;
      `MXU_REG_RXPTR: sel = 8'h20;
      `MXU_REG_RAMADR: sel = 8'h40;
      `MXU_REG_RAMDAT: sel = 8'h80;
      default: sel = 8'h00;
    endcase
    hit = |sel;
    wrStb = psel & penable & pwrite;
    rdStb = psel & penable & ~pwrite;
  end
endmodule // mxu_apb

/* hw/mxu_defs.vh */
// constants for the mailbox and execute-command unit
// assumes a 25 MHz clock, APB slave with 32-bit data, 16-bit mailbox RAM
`ifndef MXU_DEFS_VH
`define MXU_DEFS_VH
// status flag positions in a mailbox status word
`define MXU_DONE_BIT 15
`define MXU_BUSY_BIT 14
`define MXU_ERR_BIT 13
`define MXU_CODE_MSB 12
// mailbox RAM word addresses (16-bit words)
`define MXU_AW 8
`define MXU_TX_STAT 8'h00
`define MXU_TX_PTR 8'h01
`define MXU_RX_STAT 8'h02
`define MXU_RX_PTR 8'h03
`define MXU_EX_CMD 8'h04
`define MXU_EX_P1 8'h05
`define MXU_EX_P2 8'h06
`define MXU_EX_P3 8'h07
`define MXU_RING0 8'h10
// descriptor word: end-of-list flag and link field
`define MXU_EOL_BIT 15
`define MXU_LINK_MSB 7
`define MXU_EOL_FLAG 16'h8000
// execute command codes
`define MXU_CMD_FILTER 13'h0000
`define MXU_CMD_ADDR 13'h0001
// filter bit positions and defaults
`define MXU_F_PROMISC 0
`define MXU_F_BCBLOCK 1
`define MXU_F_KEEPBAD 2
`define MXU_FILTER_RST 3'h2
`define MXU_ADDR_RST 48'h000000000000
// APB register byte offsets
`define MXU_REG_CMD 12'h000
`define MXU_REG_STATUS 12'h004
`define MXU_REG_FILTER 12'h008
`define MXU_REG_ADDRHI 12'h00C
`define MXU_REG_ADDRLO 12'h010
`define MXU_REG_RXPTR 12'h014
`define MXU_REG_RAMADR 12'h018
`define MXU_REG_RAMDAT 12'h01C
// command register bits
`define MXU_CMD_EXEC 0
`define MXU_CMD_TXKICK 1
`define MXU_CMD_RXSTART 2
// receive pause time for filter reload
`define MXU_PAUSE_CYC 4'h3
`endif

/* hw/mxu_ram.v */
// mailbox RAM: 256 words of 16 bits, one write port and one read port
// assumes a single clock; read data is registered one cycle after address
module mxu_ram (
  input wire clk,
  input wire wrEn,
  input wire [7:0] wrAddr,
  input wire [15:0] wrData,
  input wire [7:0] rdAddr,
  output reg [15:0] rdData
);
  reg [15:0] mem [0:255];

  // ===========================================================
  // storage
  always @(posedge clk) begin
    if (wrEn) begin
      mem[wrAddr] <= wrData;
    end
    rdData <= mem[rdAddr];
  end
endmodule // mxu_ram

/* hw/mxu_unit.v */
// mailbox and execute-command interpreter with APB register access
// assumes host software fills the mailbox RAM through the RAM window
// registers and kicks the unit through the command register
//
// The implementer's own choices: the address map and the APB interface to the registers.
`include "mxu_defs.vh"
module mxu_unit (
  input wire clk,
  input wire rst_n,
  input wire [11:0] paddr,
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [31:0] pwdata,
  output reg [31:0] prdata,
  output reg pready,
  output reg pslverr,
  output reg rxPause,
  output reg promiscuous,
  output reg broadcastBlock,
  output reg keepBadFrames,
  output reg [47:0] stationAddr,
  output reg [7:0] rxListPtr,
  output reg rxStart
);
  // ===========================================================
  // states
  localparam S_INIT0 = 4'd0;
  localparam S_INIT1 = 4'd1;
  localparam S_IDLE = 4'd2;
  localparam S_EXRD = 4'd3;
  localparam S_EXWAIT = 4'd4;
  localparam S_EXDEC = 4'd5;
  localparam S_PAUSE = 4'd6;
  localparam S_ADDR = 4'd7;
  localparam S_DONE = 4'd8;
  localparam S_WRD = 4'd9;
  localparam S_WWAIT = 4'd10;
  localparam S_WSTEP = 4'd11;
  localparam S_RXRD = 4'd12;
  localparam S_RXWAIT = 4'd13;

  reg [3:0] state;
  reg [3:0] retState;
  reg [3:0] cnt;
  reg [1:0] addrIdx;
  reg execAck;
  reg execPend;
  reg txPend;
  reg rxPend;
  reg [7:0] walkPtr;
  reg [7:0] ramAdrReg;
  reg failFlag;
  reg [12:0] cmdCode;
  // RAM ports
  reg ramWe;
  reg [7:0] ramWa;
  reg [15:0] ramWd;
  reg [7:0] ramRa;
  wire [15:0] ramQ;
  wire [7:0] sel;
  wire wrStb;
  wire rdStb;
  wire hit;
  // host RAM-window write takes the port in any cycle the engine is not writing
  wire hostRamWr;
  // one-cycle strobe of a host write, at the first access edge
  wire hostWr;
  // host window read address while idle, engine address otherwise
  reg [7:0] ramRdAdr;
  // command code field of the word on the RAM read port
  wire [12:0] ramCode;

  // build a mailbox status word from flags
  function [15:0] statWord;
    input done;
    input busy;
    input err;
    begin
      statWord = 16'h0000;
      statWord[`MXU_DONE_BIT] = done;
      statWord[`MXU_BUSY_BIT] = busy;
      statWord[`MXU_ERR_BIT] = err;
    end
  endfunction

  // swap the halves of an address word: odd byte low, even byte high
  function [15:0] byteSwap;
    input [15:0] word;
    begin
      byteSwap = {word[7:0], word[15:8]};
    end
  endfunction

  // ===========================================================
  // submodules
  mxu_apb uApb (
    .paddr(paddr),
    .psel(psel),
    .penable(penable),
    .pwrite(pwrite),
    .sel(sel),
    .wrStb(wrStb),
    .rdStb(rdStb),
    .hit(hit)
  );

  mxu_ram uRam (
    .clk(clk),
    .wrEn(ramWe),
    .wrAddr(ramWa),
    .wrData(ramWd),
    .rdAddr(ramRdAdr),
    .rdData(ramQ)
  );

  assign hostWr = wrStb & ~pready;
  assign hostRamWr = hostWr & sel[7];
  assign ramCode = ramQ[`MXU_CODE_MSB:0];

  // ===========================================================
  // RAM port muxing: engine writes have priority over host
  reg engWe;
  reg [7:0] engWa;
  reg [15:0] engWd;
  always @* begin
    ramWe = engWe | hostRamWr;
    ramWa = engWe ? engWa : ramAdrReg;
    ramWd = engWe ? engWd : pwdata[15:0];
    // the host window reads only while the engine is idle
    ramRdAdr = (state == S_IDLE) ? ramAdrReg : ramRa;
  end

  // ===========================================================
  // APB slave: one wait cycle so the access is answered next edge
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      pready <= 1'b0;
      pslverr <= 1'b0;
      prdata <= 32'h00000000;
    end else begin
      pready <= psel & penable & ~pready;
      pslverr <= psel & penable & ~pready & ~hit;
      // read data registered at the first access edge
      if (rdStb & ~pready) begin
        case (1'b1)
          sel[0]: prdata <= {29'h0, rxPend, txPend, execPend};
          sel[1]: prdata <= {31'h0, execAck};
          sel[2]: prdata <= {29'h0, keepBadFrames, broadcastBlock,
                             promiscuous};
          sel[3]: prdata <= {16'h0000, stationAddr[47:32]};
          sel[4]: prdata <= stationAddr[31:0];
          sel[5]: prdata <= {24'h000000, rxListPtr};
          sel[6]: prdata <= {24'h000000, ramAdrReg};
          sel[7]: prdata <= {16'h0000, ramQ};
          default: prdata <= 32'h00000000;
        endcase
      end
    end
  end

  // ===========================================================
  // command register, RAM address register, acknowledge bit
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      execPend <= 1'b0;
      txPend <= 1'b0;
      rxPend <= 1'b0;
      ramAdrReg <= 8'h00;
      execAck <= 1'b0;
    end else begin
      if (wrStb & ~pready & sel[6]) begin
        ramAdrReg <= pwdata[7:0];
      end
      // hardware set wins over a host clear in the same cycle
      if (state == S_DONE) begin
        execAck <= 1'b1;
      end else if (wrStb & ~pready & sel[1] & pwdata[0]) begin
        execAck <= 1'b0;
      end
      // host sets pending bits; the engine clears each once taken
      if (wrStb & ~pready & sel[0] & pwdata[`MXU_CMD_EXEC]) begin
        execPend <= 1'b1;
      end else if (state == S_EXRD) begin
        execPend <= 1'b0;
      end
      if (wrStb & ~pready & sel[0] & pwdata[`MXU_CMD_TXKICK]) begin
        txPend <= 1'b1;
      end else if (state == S_WRD && retState == S_IDLE) begin
        txPend <= 1'b0;
      end
      if (wrStb & ~pready & sel[0] & pwdata[`MXU_CMD_RXSTART]) begin
        rxPend <= 1'b1;
      end else if (state == S_RXRD) begin
        rxPend <= 1'b0;
      end
    end
  end

  // ===========================================================
  // engine: reset init, execute mailbox, list walk, receive start
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      state <= S_INIT0;
      retState <= S_IDLE;
      cnt <= 4'h0;
      addrIdx <= 2'd0;
      walkPtr <= 8'h00;
      failFlag <= 1'b0;
      cmdCode <= 13'h0000;
      engWe <= 1'b0;
      engWa <= 8'h00;
      engWd <= 16'h0000;
      ramRa <= 8'h00;
      rxPause <= 1'b0;
      promiscuous <= 1'b0;
      broadcastBlock <= 1'b1;
      keepBadFrames <= 1'b0;
      stationAddr <= `MXU_ADDR_RST;
      rxListPtr <= 8'h00;
      rxStart <= 1'b0;
    end else begin
      engWe <= 1'b0;
      rxStart <= 1'b0;
      case (state)
        // flag the first ring descriptor, then point at it
        S_INIT0: begin
          engWe <= 1'b1;
          engWa <= `MXU_RING0;
          engWd <= `MXU_EOL_FLAG | {8'h00, `MXU_RING0};
          state <= S_INIT1;
        end
        S_INIT1: begin
          engWe <= 1'b1;
          engWa <= `MXU_TX_PTR;
          engWd <= {8'h00, `MXU_RING0};
          walkPtr <= `MXU_RING0;
          state <= S_IDLE;
        end
        // execute first, then the list walk, then receive start
        S_IDLE: begin
          if (execPend) begin
            ramRa <= `MXU_EX_CMD;
            state <= S_EXRD;
          end else if (txPend) begin
            ramRa <= walkPtr;
            retState <= S_IDLE;
            state <= S_WRD;
          end else if (rxPend) begin
            ramRa <= `MXU_RX_PTR;
            state <= S_RXRD;
          end
        end
        // command word read; busy is written once the code is decoded
        S_EXRD: state <= S_EXWAIT;
        S_EXWAIT: state <= S_EXDEC;
        S_EXDEC: begin
          cmdCode <= ramCode;
          // mark the word busy, keeping the host's code
          engWe <= 1'b1;
          engWa <= `MXU_EX_CMD;
          engWd <= statWord(1'b0, 1'b1, 1'b0) |
                   {3'b000, ramCode};
          failFlag <= 1'b0;
          if (ramCode == `MXU_CMD_FILTER) begin
            ramRa <= `MXU_EX_P1;
            rxPause <= 1'b1;
            cnt <= `MXU_PAUSE_CYC;
            state <= S_PAUSE;
          end else if (ramCode == `MXU_CMD_ADDR) begin
            ramRa <= `MXU_EX_P1;
            addrIdx <= 2'd0;
            cnt <= 4'h0;
            state <= S_ADDR;
          end else begin
            // unrecognised code: done with error, no further work
            failFlag <= 1'b1;
            state <= S_DONE;
          end
        end
        // receive paused while the filter word loads
        S_PAUSE: begin
          if (cnt == 4'h0) begin
            promiscuous <= ramQ[`MXU_F_PROMISC];
            broadcastBlock <= ramQ[`MXU_F_BCBLOCK];
            keepBadFrames <= ramQ[`MXU_F_KEEPBAD];
            rxPause <= 1'b0;
            state <= S_DONE;
          end else begin
            cnt <= cnt - 4'h1;
          end
        end
        // three address words, low byte even, high byte odd
        S_ADDR: begin
          if (cnt == 4'h0) begin
            cnt <= 4'h1;
          end else begin
            cnt <= 4'h0;
            case (addrIdx)
              2'd0: stationAddr[47:32] <= byteSwap(ramQ);
              2'd1: stationAddr[31:16] <= byteSwap(ramQ);
              default: stationAddr[15:0] <= byteSwap(ramQ);
            endcase
            if (addrIdx == 2'd2) begin
              state <= S_DONE;
            end else begin
              addrIdx <= addrIdx + 2'd1;
              ramRa <= ramRa + 8'h01;
            end
          end
        end
        // done set, busy cleared, error on failure
        S_DONE: begin
          engWe <= 1'b1;
          engWa <= `MXU_EX_CMD;
          engWd <= statWord(1'b1, 1'b0, failFlag) |
                   {3'b000, cmdCode};
          state <= S_IDLE;
        end
        // follow the link chain until the flagged descriptor
        S_WRD: state <= S_WWAIT;
        S_WWAIT: state <= S_WSTEP;
        S_WSTEP: begin
          if (ramQ[`MXU_EOL_BIT]) begin
            engWe <= 1'b1;
            engWa <= `MXU_TX_PTR;
            engWd <= {8'h00, walkPtr};
            state <= S_IDLE;
          end else begin
            walkPtr <= ramQ[`MXU_LINK_MSB:0];
            ramRa <= ramQ[`MXU_LINK_MSB:0];
            retState <= S_WSTEP;
            state <= S_WRD;
          end
        end
        // receive pointer word is fetched only on a start command
        S_RXRD: state <= S_RXWAIT;
        S_RXWAIT: begin
          rxListPtr <= ramQ[7:0];
          rxStart <= 1'b1;
          state <= S_IDLE;
        end
        default: state <= S_IDLE;
      endcase
    end
  end
endmodule // mxu_unit

/* tb/mxu_host_model.sv */
// host driver model: APB master that reaches the mailbox unit
// assumes tasks are called just after a rising clock edge
// ==========================================================
// host model
module mxu_host_model (
  input wire clk,
  input wire [31:0] prdata,
  input wire pready,
  input wire pslverr,
  output logic [11:0] paddr,
  output logic psel,
  output logic penable,
  output logic pwrite,
  output logic [31:0] pwdata
);
  timeunit 1ns;
  timeprecision 1ps;
  // bus idle at time zero
  initial begin
    paddr = 12'h000;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    pwdata = 32'h0;
  end
  // one transfer: setup, access held until pready, then release
  task automatic xfer(input logic w, input logic [11:0] a,
                      input logic [31:0] d, output logic [31:0] r,
                      output logic e);
    paddr <= a;
    pwrite <= w;
    pwdata <= d;
    psel <= 1'b1;
    penable <= 1'b0;
    @(posedge clk);
    penable <= 1'b1;
    do begin
      @(posedge clk);
    end while (pready !== 1'b1);
    r = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge clk);
  endtask
endmodule // mxu_host_model

/* tb/mxu_unit_properties.sv */
// checker for the mailbox unit: APB answers and output relations
// assumes it is bound to mxu_unit and sees only its ports
// ==========================================================
// checker module
module mxu_unit_checker (
  input wire clk,
  input wire rst_n,
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [31:0] prdata,
  input wire pready,
  input wire pslverr,
  input wire rxPause,
  input wire promiscuous,
  input wire broadcastBlock,
  input wire keepBadFrames,
  input wire [47:0] stationAddr,
  input wire [7:0] rxListPtr,
  input wire rxStart
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!rst_n);
  // bus answer shape
  ready_in_access_a: assert property (pready |-> psel && penable)
    else $error("pready outside an access phase");
  ready_pulse_a: assert property (pready |=> !pready)
    else $error("pready held longer than one cycle");
  ready_timing_a: assert property ($rose(penable) && psel |=> pready)
    else $error("pready late after access phase");
  slverr_with_ready_a: assert property (pslverr |-> pready)
    else $error("pslverr without pready");
  refused_read_a: assert property (pready && pslverr && !pwrite
    |-> prdata == 32'h0)
    else $error("refused read returned data");
  // receive pause and filter reload
  pause_length_a: assert property (
    $rose(rxPause) |-> rxPause [*4] ##1 !rxPause)
    else $error("receive pause length wrong");
  filter_in_pause_a: assert property (
    $changed({promiscuous, broadcastBlock, keepBadFrames})
    |-> rxPause || $past(rxPause))
    else $error("filter changed outside receive pause");
  // receive pointer and reset state
  rxptr_on_start_a: assert property (
    $changed(rxListPtr) |-> rxStart || $past(rxStart))
    else $error("receive pointer changed without start");
  reset_values_a: assert property (
    $rose(rst_n) |-> broadcastBlock && !promiscuous && !keepBadFrames
    && stationAddr == 48'h0)
    else $error("output reset values wrong");
endmodule // mxu_unit_checker

/* tb/mxu_unit_tb.sv */
// testbench for the mailbox and execute-command unit
// assumes the host model drives APB; mailbox RAM reached via window
`include "mxu_defs.vh"
// ==========================================================
// bench top
module mxu_unit_tb;
  timeunit 1ns;
  timeprecision 1ps;
  typedef struct {
    logic [15:0] cmd, p1, p2, p3, stat;
    logic [2:0] filt;
    logic [47:0] addr;
  } mxu_row_t;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic pauseSeen = 1'b0;
  logic startSeen = 1'b0;
  int errCount = 0;
  int comparisons = 0;
  int cycles = 0;
  wire [11:0] paddr;
  wire psel, penable, pwrite, pready, pslverr;
  wire [31:0] pwdata, prdata;
  wire rxPause, promiscuous, broadcastBlock, keepBadFrames, rxStart;
  wire [47:0] stationAddr;
  wire [7:0] rxListPtr;
  // execute rows: command, params, final status, filter, address
  mxu_row_t rows [6] = '{
    '{16'h0000, 16'h0005, 16'h0, 16'h0, 16'h8000, 3'b101, 48'h0},
    '{16'h0000, 16'h0002, 16'h0, 16'h0, 16'h8000, 3'b010, 48'h0},
    '{16'h0001, 16'h2211, 16'h4433, 16'h6655, 16'h8001, 3'b010,
      48'h112233445566},
    '{16'h0007, 16'h0, 16'h0, 16'h0, 16'hA007, 3'b010, 48'h112233445566},
    '{16'h1FFF, 16'h0, 16'h0, 16'h0, 16'hBFFF, 3'b010, 48'h112233445566},
    '{16'h0000, 16'h0003, 16'h0, 16'h0, 16'h8000, 3'b011,
      48'h112233445566}};
  always #20 clk = ~clk;
  mxu_unit u_dut (.clk(clk), .rst_n(rst_n), .paddr(paddr), .psel(psel),
    .penable(penable), .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .rxPause(rxPause),
    .promiscuous(promiscuous), .broadcastBlock(broadcastBlock),
    .keepBadFrames(keepBadFrames), .stationAddr(stationAddr),
    .rxListPtr(rxListPtr), .rxStart(rxStart));
  mxu_host_model u_host (.clk(clk), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .paddr(paddr), .psel(psel), .penable(penable),
    .pwrite(pwrite), .pwdata(pwdata));
  // ==========================================================
  // watchers and timeout
  always @(posedge clk) begin
    if (rxPause === 1'b1) pauseSeen <= 1'b1;
    if (rxStart === 1'b1) startSeen <= 1'b1;
    cycles++;
    if (cycles == 20000) begin
      errCount++;
      printVerdict();
    end
  end
  // ==========================================================
  // helpers
  task automatic printVerdict;
    $display("comparisons %0d mismatches %0d", comparisons, errCount);
    if (errCount == 0 && comparisons > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask
  task automatic chk(input string n, input logic [47:0] e,
                     input logic [47:0] g);
    comparisons++;
    if (g !== e) begin
      errCount++;
      $display("mismatch %s expected %h seen %h", n, e, g);
    end
  endtask
  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    logic [31:0] r;
    logic e;
    u_host.xfer(1'b1, a, d, r, e);
  endtask
  task automatic rd(input logic [11:0] a, output logic [31:0] r);
    logic e;
    u_host.xfer(1'b0, a, 32'h0, r, e);
  endtask
  task automatic ramWr(input logic [7:0] a, input logic [15:0] d);
    wr(`MXU_REG_RAMADR, {24'h0, a});
    wr(`MXU_REG_RAMDAT, {16'h0, d});
  endtask
  task automatic ramRd(input logic [7:0] a, output logic [15:0] w);
    logic [31:0] r;
    wr(`MXU_REG_RAMADR, {24'h0, a});
    rd(`MXU_REG_RAMDAT, r);
    w = r[15:0];
  endtask
  // ==========================================================
  // main sequence
  initial begin
    int n;
    logic [31:0] r;
    logic [15:0] w;
    logic e;
    repeat (3) @(posedge clk);
    rst_n <= 1'b1;
    @(posedge clk);
    chk("broadcastBlock", 1, broadcastBlock);
    chk("promiscuous", 0, promiscuous);
    chk("keepBadFrames", 0, keepBadFrames);
    chk("stationAddr", 0, stationAddr);
    repeat (3) @(posedge clk);
    ramRd(`MXU_TX_PTR, w);
    chk("txPtr", 16'h0010, w);
    ramRd(`MXU_RING0, w);
    chk("ringFlag", 1, w[`MXU_EOL_BIT]);
    foreach (rows[i]) begin
      ramWr(`MXU_EX_CMD, rows[i].cmd);
      ramWr(`MXU_EX_P1, rows[i].p1);
      ramWr(`MXU_EX_P2, rows[i].p2);
      ramWr(`MXU_EX_P3, rows[i].p3);
      wr(`MXU_REG_CMD, 32'h1);
      r = 32'h0;
      for (n = 0; n < 40 && r[0] !== 1'b1; n++) rd(`MXU_REG_STATUS, r);
      chk("execAck", 1, r[0]);
      ramRd(`MXU_EX_CMD, w);
      chk("execStatus", rows[i].stat, w);
      chk("filter", rows[i].filt,
          {keepBadFrames, broadcastBlock, promiscuous});
      chk("stationAddr", rows[i].addr, stationAddr);
      wr(`MXU_REG_STATUS, 32'h1);
      rd(`MXU_REG_STATUS, r);
      chk("ackCleared", 0, r[0]);
    end
    chk("pauseSeen", 1, pauseSeen);
    // move the end-of-list flag forward two descriptors
    ramWr(`MXU_TX_STAT, 16'h0);
    ramWr(8'h12, 16'h8013);
    ramWr(8'h11, 16'h0012);
    ramWr(`MXU_RING0, 16'h0011);
    wr(`MXU_REG_CMD, 32'h2);
    w = 16'h0;
    for (n = 0; n < 40 && w !== 16'h0012; n++) ramRd(`MXU_TX_PTR, w);
    chk("txPtrWalk", 16'h0012, w);
    // receive pointer taken only on start
    ramWr(`MXU_RX_STAT, 16'h0);
    ramWr(`MXU_RX_PTR, 16'h0040);
    chk("rxPtrEarly", 0, rxListPtr);
    wr(`MXU_REG_CMD, 32'h4);
    for (n = 0; n < 40 && !startSeen; n++) @(posedge clk);
    chk("rxListPtr", 8'h40, rxListPtr);
    rd(`MXU_REG_RXPTR, r);
    chk("rxPtrReg", 32'h40, r);
    // refused and read-only accesses
    u_host.xfer(1'b0, 12'h020, 32'h0, r, e);
    chk("slverr", 1, e);
    chk("unmappedData", 0, r);
    wr(`MXU_REG_FILTER, 32'h0);
    rd(`MXU_REG_FILTER, r);
    chk("filterReadOnly", 32'h3, r);
    // reset again in mid-run
    rst_n <= 1'b0;
    repeat (3) @(posedge clk);
    rst_n <= 1'b1;
    @(posedge clk);
    chk("addrAfterReset", 0, stationAddr);
    chk("filterAfterReset", 3'b010,
        {keepBadFrames, broadcastBlock, promiscuous});
    repeat (3) @(posedge clk);
    ramRd(`MXU_TX_PTR, w);
    chk("txPtrAfterReset", 16'h0010, w);
    printVerdict();
  end
endmodule // mxu_unit_tb
bind mxu_unit mxu_unit_checker u_chk (.clk(clk), .rst_n(rst_n),
  .psel(psel), .penable(penable), .pwrite(pwrite), .prdata(prdata),
  .pready(pready), .pslverr(pslverr), .rxPause(rxPause),
  .promiscuous(promiscuous), .broadcastBlock(broadcastBlock),
  .keepBadFrames(keepBadFrames), .stationAddr(stationAddr),
  .rxListPtr(rxListPtr), .rxStart(rxStart));
